// [design/trs_pkg.sv]
`default_nettype none
package trs_pkg;
	localparam longint unsigned TRS_CLK_HZ     = 20_000_000;
	localparam longint unsigned TRS_E1_REF_HZ  = 2_048_000;
	localparam longint unsigned TRS_T1_REF_HZ  = 1_544_000;
	localparam longint unsigned TRS_STM_REF_HZ = 2_048_000;
	localparam longint unsigned TRS_GATE_MS    = 1000;
	localparam longint unsigned TRS_GATE_CYCLES = TRS_CLK_HZ * TRS_GATE_MS / 1000;
	localparam longint unsigned TRS_MINUTE_S   = 60;
	localparam longint unsigned TRS_MINUTE_CYCLES = TRS_CLK_HZ * TRS_MINUTE_S;
	localparam longint unsigned TRS_PPM_LIMIT  = 12;
	localparam longint unsigned TRS_PPM_SCALE  = 1_000_000;
	localparam logic [3:0]      TRS_RESTORE_MAX     = 4'hC;
	localparam logic [3:0]      TRS_RESTORE_DEFAULT = 4'h5;
	localparam logic [3:0]      TRS_SSM_DNU   = 4'hF;
	localparam logic [3:0]      TRS_SSM_QU    = 4'h0;
	localparam logic [3:0]      TRS_SSM_PRC   = 4'h2;
	localparam logic [3:0]      TRS_SSM_SSUT  = 4'h4;
	localparam logic [3:0]      TRS_SSM_SSUL  = 4'h8;
	localparam logic [3:0]      TRS_SSM_SEC   = 4'hB;
	localparam int              TRS_SYNC_W    = 20;

	typedef enum logic [1:0] {TRS_FREE_RUN, TRS_NORMAL, TRS_HOLDOVER} trs_state_type;
	typedef enum logic [1:0] {TRS_SRC_STM_PAIR, TRS_SRC_STM_SINGLE, TRS_SRC_E1_PAIR} trs_src_type;
	typedef enum logic [2:0] {
		TRS_CMD_CLEAR, TRS_CMD_LOCKOUT, TRS_CMD_FORCE_SEC,
		TRS_CMD_FORCE_PRI, TRS_CMD_MAN_SEC, TRS_CMD_MAN_PRI
	} trs_cmd_type;
	typedef enum logic [1:0] {TRS_REF_UNAVAIL, TRS_REF_STANDBY, TRS_REF_ACTIVE} trs_ref_type;
	typedef enum logic [1:0] {
		TRS_OP_NONE, TRS_OP_NORMAL, TRS_OP_UNAVAIL_REF, TRS_OP_RESTORE_WAIT
	} trs_op_type;

	function automatic logic [31:0] trs_expected(input longint unsigned rate_hz,
		input longint unsigned gate);
		longint unsigned full;
		full = rate_hz * gate / TRS_CLK_HZ;
		return full[31:0];
	endfunction : trs_expected

	function automatic logic trs_ssm_bad(input logic [3:0] code);
		logic known;
		known = (code == TRS_SSM_QU) || (code == TRS_SSM_PRC) || (code == TRS_SSM_SSUT)
			|| (code == TRS_SSM_SSUL) || (code == TRS_SSM_SEC);
		return (code == TRS_SSM_DNU) || !known;
	endfunction : trs_ssm_bad
endpackage : trs_pkg
`default_nettype wire

// [design/trs_mon_if.sv]
`default_nettype none
interface trs_mon_if;
	logic        ref_lvl;
	logic [31:0] expected;
	logic [31:0] measured;
	logic        freq_ok;
	modport mon (input ref_lvl, input expected, output measured, output freq_ok);
	modport ctl (output ref_lvl, output expected, input measured, input freq_ok);
endinterface : trs_mon_if
`default_nettype wire

// [design/trs_freq_mon.sv]
`default_nettype none
module trs_freq_mon
	import trs_pkg::*;
#(
	parameter longint unsigned GATE_CYCLES = TRS_GATE_CYCLES
) (
	input wire logic clk_sys,
	input wire logic rstn,
	trs_mon_if.mon   mon
);
	localparam logic [31:0] GATE_LAST = 32'(GATE_CYCLES - 1);
	localparam logic [63:0] PPM_LIM   = 64'(TRS_PPM_LIMIT);
	localparam logic [63:0] PPM_SCL   = 64'(TRS_PPM_SCALE);

	logic        ref_d_reg;
	logic [31:0] gate_reg;
	logic [31:0] edges_reg;
	logic [31:0] meas_reg;
	logic        ok_reg;
	logic        rise;
	logic [31:0] total;
	logic [31:0] diff;

	assign rise  = mon.ref_lvl & ~ref_d_reg;
	assign total = edges_reg + {31'h0, rise};
	assign diff  = (total > mon.expected) ? total - mon.expected : mon.expected - total;
	assign mon.measured = meas_reg;
	assign mon.freq_ok  = ok_reg;

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			ref_d_reg <= 1'b0;
		end else begin
			ref_d_reg <= mon.ref_lvl;
		end
	end

	// Edge count over a fixed gate, judged at each gate end
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			gate_reg  <= 32'h0;
			edges_reg <= 32'h0;
			meas_reg  <= 32'h0;
			ok_reg    <= 1'b0;
		end else if (gate_reg == GATE_LAST) begin
			gate_reg  <= 32'h0;
			edges_reg <= 32'h0;
			meas_reg  <= total;
			ok_reg    <= (total != 32'h0)
				&& ({32'h0, diff} * PPM_SCL < PPM_LIM * {32'h0, mon.expected});
		end else begin
			gate_reg  <= gate_reg + 32'h1;
			edges_reg <= total;
		end
	end
endmodule : trs_freq_mon
`default_nettype wire

// [design/trs_timing_ref_sel.sv]
// What this block does
// - Two timing modes: Internal free-run, or Auto locking to primary/secondary.
// - After reset the block is in Internal mode until Auto is configured.
// - Entering Auto, stay free-run until a reference becomes valid.
// - Pair one: STM-1 port one primary, port two secondary, line timing.
// - Line variant pair two: E1 ports 7 and 8, valid only if both carry traffic.
// - Other variant: 2.048-MHz clock on E1 ports 20 and 21 as sync inputs.
// - T1 base ports: accept 1.544-MHz clock on the pair as sync inputs.
// - Both references available at lock-in, no Forced-Secondary: primary active, secondary standby.
// - Normal whenever locked to primary or secondary.
// - From Normal enter Holdover when both references are unavailable.
// - Also Holdover if primary lost, secondary up, Lockout or Forced-Primary present.
// - Leave Holdover for Normal once primary, or secondary without Lockout or Forced-Primary, is available again.
// - Primary failure moves to secondary automatically, without a phase hit.
// - No automatic switch to secondary under Lockout or Forced-Primary.
// - Unavailable on LOS, LOF, MS-AIS, DNU or invalid SSM, or E1 LOS.
// - Unavailable when frequency is off nominal by 12 ppm or more.
// - Raise an alarm whenever primary or secondary fails.
// - Single STM-1 port setting: straight to Holdover when that port fails.
// - Single unprotected STM-1: Auto still runs, one reference always unavailable.
// - Report active or standby per available reference, plus SSM if enabled.
// - Operation status Normal when both available, one active, one standby, no restore wait running.
// - Status unavailable-reference when any lost under Lockout or Forced-Primary.
// - Revertive: back to primary automatically after the restore delay expires.
// - Non-revertive: stay on secondary until command or secondary failure.
// - Restore delay in whole minutes 0 to 12, default 5, revertive only.
// - Commands ranked Clear, Lockout, Forced, Manual; lower refused under higher.
`default_nettype none
module trs_timing_ref_sel
	import trs_pkg::*;
#(
	parameter longint unsigned GATE_CYCLES   = TRS_GATE_CYCLES,
	parameter longint unsigned MINUTE_CYCLES = TRS_MINUTE_CYCLES
) (
	input  wire logic        clk_sys,
	input  wire logic        rstn,
	input  wire logic        mode_auto,
	input  wire trs_src_type src_sel,
	input  wire logic        e1_sync_variant,
	input  wire logic        base_t1,
	input  wire logic [1:0]  e1_traffic,
	input  wire logic [1:0]  e1_sync_in,
	input  wire logic        stm_single_unprot,
	input  wire logic        revertive,
	input  wire logic [3:0]  restore_delay_min,
	input  wire logic        ssm_enable,
	input  wire logic [1:0]  stm_ref_clk,
	input  wire logic [1:0]  e1_ref_clk,
	input  wire logic [1:0]  stm_los,
	input  wire logic [1:0]  stm_lof,
	input  wire logic [1:0]  stm_msais,
	input  wire logic [1:0]  e1_los,
	input  wire logic [3:0]  ssm_code_pri,
	input  wire logic [3:0]  ssm_code_sec,
	input  wire logic        cmd_valid,
	input  wire trs_cmd_type cmd_code,
	output trs_state_type    timing_state,
	output logic             active_sec,
	output trs_ref_type      pri_status,
	output trs_ref_type      sec_status,
	output logic [3:0]       pri_ssm,
	output logic [3:0]       sec_ssm,
	output trs_op_type       op_status,
	output logic             pri_alarm,
	output logic             sec_alarm,
	output logic             cmd_accept,
	output logic             cmd_deny,
	output logic             lockout_on,
	output logic             forced_on,
	output logic [31:0]      freq_word
);
	localparam logic [31:0] EXP_E1  = trs_expected(TRS_E1_REF_HZ, GATE_CYCLES);
	localparam logic [31:0] EXP_T1  = trs_expected(TRS_T1_REF_HZ, GATE_CYCLES);
	localparam logic [31:0] EXP_STM = trs_expected(TRS_STM_REF_HZ, GATE_CYCLES);
	localparam logic [31:0] MIN_LAST = 32'(MINUTE_CYCLES - 1);

	trs_mon_if mon_p ();
	trs_mon_if mon_s ();

	logic [TRS_SYNC_W-1:0] sync1_reg;
	logic [TRS_SYNC_W-1:0] sync2_reg;
	logic [TRS_SYNC_W-1:0] raw;
	logic [1:0]  s_stm_clk, s_e1_clk, s_stm_los, s_stm_lof, s_stm_ais, s_e1_los;
	logic [3:0]  s_ssm_p, s_ssm_s;

	trs_state_type state_reg, state_next;
	logic        sec_reg, sec_next;
	logic        lockout_reg, fpri_reg, fsec_reg, forced_reg;
	logic        man_go_reg, man_sec_reg;
	logic        accept_reg, deny_reg;
	logic [31:0] cyc_reg;
	logic [3:0]  min_reg;
	trs_ref_type pri_st_reg, sec_st_reg;
	logic [3:0]  pri_ssm_reg, sec_ssm_reg;
	trs_op_type  op_reg;
	logic        pri_alm_reg, sec_alm_reg;
	logic [31:0] freq_reg;

	logic        e1_pair, p_cfg, s_cfg, p_def, s_def, p_av, s_av;
	logic        pri_lock, sec_ok, usable, wait_run, restore_done;
	logic [3:0]  delay_lim;
	logic [31:0] nominal;

	// Line-side levels and recovered clocks cross into clk_sys
	assign raw = {ssm_code_sec, ssm_code_pri, e1_los, stm_msais, stm_lof, stm_los,
		e1_ref_clk, stm_ref_clk};

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			sync1_reg <= '0;
			sync2_reg <= '0;
		end else begin
			sync1_reg <= raw;
			sync2_reg <= sync1_reg;
		end
	end

	assign {s_ssm_p, s_e1_los, s_stm_ais, s_stm_lof, s_stm_los, s_e1_clk, s_stm_clk}
		= {sync2_reg[15:12], sync2_reg[11:0]};
	assign s_ssm_s = sync2_reg[19:16];

	assign e1_pair = (src_sel == TRS_SRC_E1_PAIR);
	assign nominal = !e1_pair ? EXP_STM : base_t1 ? EXP_T1 : EXP_E1;

	assign mon_p.ref_lvl  = e1_pair ? s_e1_clk[0] : s_stm_clk[0];
	assign mon_s.ref_lvl  = e1_pair ? s_e1_clk[1] : s_stm_clk[1];
	assign mon_p.expected = nominal;
	assign mon_s.expected = nominal;

	trs_freq_mon #(.GATE_CYCLES(GATE_CYCLES)) u_mon_p (
		.clk_sys (clk_sys),
		.rstn    (rstn),
		.mon     (mon_p)
	);

	trs_freq_mon #(.GATE_CYCLES(GATE_CYCLES)) u_mon_s (
		.clk_sys (clk_sys),
		.rstn    (rstn),
		.mon     (mon_s)
	);

	// Which candidates exist in the chosen setting
	always_comb begin
		if (e1_pair) begin
			p_cfg = e1_sync_variant ? e1_sync_in[0] : &e1_traffic;
			s_cfg = e1_sync_variant ? e1_sync_in[1] : &e1_traffic;
		end else begin
			p_cfg = 1'b1;
			s_cfg = (src_sel == TRS_SRC_STM_PAIR) && !stm_single_unprot;
		end
	end

	always_comb begin
		if (e1_pair) begin
			p_def = s_e1_los[0];
			s_def = s_e1_los[1];
		end else begin
			p_def = s_stm_los[0] | s_stm_lof[0] | s_stm_ais[0]
				| (ssm_enable & trs_ssm_bad(s_ssm_p));
			s_def = s_stm_los[1] | s_stm_lof[1] | s_stm_ais[1]
				| (ssm_enable & trs_ssm_bad(s_ssm_s));
		end
	end

	assign p_av = mode_auto & p_cfg & !p_def & mon_p.freq_ok;
	assign s_av = mode_auto & s_cfg & !s_def & mon_s.freq_ok;

	assign pri_lock = lockout_reg | fpri_reg;
	assign sec_ok   = s_av & !pri_lock;
	assign usable   = p_av | sec_ok;

	// External commands, held ones and one-shot manual
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			lockout_reg <= 1'b0;
			fpri_reg    <= 1'b0;
			fsec_reg    <= 1'b0;
			forced_reg  <= 1'b0;
			man_go_reg  <= 1'b0;
			man_sec_reg <= 1'b0;
			accept_reg  <= 1'b0;
			deny_reg    <= 1'b0;
		end else begin
			man_go_reg <= 1'b0;
			accept_reg <= 1'b0;
			deny_reg   <= 1'b0;
			if (cmd_valid) begin
				unique case (cmd_code)
					TRS_CMD_CLEAR: begin
						lockout_reg <= 1'b0;
						fpri_reg    <= 1'b0;
						fsec_reg    <= 1'b0;
						forced_reg  <= 1'b0;
						accept_reg  <= 1'b1;
					end
					TRS_CMD_LOCKOUT: begin
						lockout_reg <= 1'b1;
						fpri_reg    <= 1'b0;
						fsec_reg    <= 1'b0;
						forced_reg  <= 1'b0;
						accept_reg  <= 1'b1;
					end
					TRS_CMD_FORCE_SEC: begin
						if (lockout_reg || !s_av) begin
							deny_reg <= 1'b1;
						end else begin
							fsec_reg   <= 1'b1;
							fpri_reg   <= 1'b0;
							forced_reg <= 1'b1;
							accept_reg <= 1'b1;
						end
					end
					TRS_CMD_FORCE_PRI: begin
						if (lockout_reg) begin
							deny_reg <= 1'b1;
						end else begin
							fpri_reg   <= 1'b1;
							fsec_reg   <= 1'b0;
							forced_reg <= 1'b1;
							accept_reg <= 1'b1;
						end
					end
					TRS_CMD_MAN_SEC, TRS_CMD_MAN_PRI: begin
						if (lockout_reg || fpri_reg || fsec_reg
							|| ((cmd_code == TRS_CMD_MAN_SEC) ? !s_av : !p_av)) begin
							deny_reg <= 1'b1;
						end else begin
							man_go_reg  <= 1'b1;
							man_sec_reg <= (cmd_code == TRS_CMD_MAN_SEC);
							accept_reg  <= 1'b1;
						end
					end
					default: begin
						deny_reg <= 1'b1;
					end
				endcase
			end
		end
	end

	// Reference choice and timing state
	always_comb begin
		state_next = state_reg;
		sec_next   = sec_reg;
		if (!mode_auto) begin
			state_next = TRS_FREE_RUN;
			sec_next   = 1'b0;
		end else begin
			unique case (state_reg)
				TRS_FREE_RUN: begin
					if (usable) begin
						state_next = TRS_NORMAL;
						sec_next   = !p_av || (fsec_reg && s_av);
					end
				end
				TRS_NORMAL, TRS_HOLDOVER: begin
					if (!usable) begin
						state_next = TRS_HOLDOVER;
					end else begin
						state_next = TRS_NORMAL;
						if (fsec_reg && s_av) begin
							sec_next = 1'b1;
						end else if (fpri_reg) begin
							sec_next = 1'b0;
						end else if (man_go_reg) begin
							sec_next = man_sec_reg;
						end else if (!sec_reg && !p_av) begin
							sec_next = 1'b1;
						end else if (sec_reg && !s_av) begin
							sec_next = 1'b0;
						end else if (sec_reg && restore_done) begin
							sec_next = 1'b0;
						end
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			state_reg <= TRS_FREE_RUN;
			sec_reg   <= 1'b0;
		end else begin
			state_reg <= state_next;
			sec_reg   <= sec_next;
		end
	end

	// Wait-to-restore timer in whole minutes
	assign delay_lim = (restore_delay_min > TRS_RESTORE_MAX) ? TRS_RESTORE_MAX
		: restore_delay_min;
	assign wait_run = revertive && (state_reg == TRS_NORMAL) && sec_reg && p_av
		&& !fsec_reg;
	assign restore_done = wait_run && (min_reg >= delay_lim);

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			cyc_reg <= 32'h0;
			min_reg <= 4'h0;
		end else if (!wait_run) begin
			cyc_reg <= 32'h0;
			min_reg <= 4'h0;
		end else if (min_reg < delay_lim) begin
			if (cyc_reg == MIN_LAST) begin
				cyc_reg <= 32'h0;
				min_reg <= min_reg + 4'h1;
			end else begin
				cyc_reg <= cyc_reg + 32'h1;
			end
		end
	end

	// Reported status
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			pri_st_reg  <= TRS_REF_UNAVAIL;
			sec_st_reg  <= TRS_REF_UNAVAIL;
			pri_ssm_reg <= 4'h0;
			sec_ssm_reg <= 4'h0;
			pri_alm_reg <= 1'b0;
			sec_alm_reg <= 1'b0;
		end else begin
			pri_st_reg <= !p_av ? TRS_REF_UNAVAIL
				: (state_reg == TRS_NORMAL && !sec_reg) ? TRS_REF_ACTIVE
				: TRS_REF_STANDBY;
			sec_st_reg <= !s_av ? TRS_REF_UNAVAIL
				: (state_reg == TRS_NORMAL && sec_reg) ? TRS_REF_ACTIVE
				: TRS_REF_STANDBY;
			pri_ssm_reg <= (p_av && ssm_enable) ? s_ssm_p : 4'h0;
			sec_ssm_reg <= (s_av && ssm_enable) ? s_ssm_s : 4'h0;
			pri_alm_reg <= mode_auto && p_cfg && !p_av;
			sec_alm_reg <= mode_auto && s_cfg && !s_av;
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			op_reg <= TRS_OP_NONE;
		end else if (pri_lock && mode_auto && (!p_av || !s_av)) begin
			op_reg <= TRS_OP_UNAVAIL_REF;
		end else if (wait_run && !restore_done) begin
			op_reg <= TRS_OP_RESTORE_WAIT;
		end else if (p_av && s_av && state_reg == TRS_NORMAL) begin
			op_reg <= TRS_OP_NORMAL;
		end else begin
			op_reg <= TRS_OP_NONE;
		end
	end

	// Output frequency: tracks the locked source, frozen in holdover
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			freq_reg <= 32'h0;
		end else begin
			unique case (state_reg)
				TRS_FREE_RUN: freq_reg <= nominal;
				TRS_NORMAL:   freq_reg <= sec_reg ? (mon_s.freq_ok ? mon_s.measured : freq_reg)
					: (mon_p.freq_ok ? mon_p.measured : freq_reg);
				TRS_HOLDOVER: freq_reg <= freq_reg;
			endcase
		end
	end

	assign timing_state = state_reg;
	assign active_sec   = sec_reg;
	assign pri_status   = pri_st_reg;
	assign sec_status   = sec_st_reg;
	assign pri_ssm      = pri_ssm_reg;
	assign sec_ssm      = sec_ssm_reg;
	assign op_status    = op_reg;
	assign pri_alarm    = pri_alm_reg;
	assign sec_alarm    = sec_alm_reg;
	assign cmd_accept   = accept_reg;
	assign cmd_deny     = deny_reg;
	assign lockout_on   = lockout_reg;
	assign forced_on    = forced_reg;
	assign freq_word    = freq_reg;
endmodule : trs_timing_ref_sel
`default_nettype wire

// [dv/trs_timing_ref_sel_sva.sv]
`default_nettype none
module trs_timing_ref_sel_sva
	import trs_pkg::*;
(
	input wire logic          clk_sys,
	input wire logic          rstn,
	input wire logic          mode_auto,
	input wire trs_src_type   src_sel,
	input wire logic          cmd_valid,
	input wire trs_cmd_type   cmd_code,
	input wire trs_state_type timing_state,
	input wire logic          active_sec,
	input wire trs_ref_type   pri_status,
	input wire trs_ref_type   sec_status,
	input wire logic [3:0]    pri_ssm,
	input wire trs_op_type    op_status,
	input wire logic          pri_alarm,
	input wire logic          sec_alarm,
	input wire logic          cmd_accept,
	input wire logic          cmd_deny,
	input wire logic          lockout_on,
	input wire logic          forced_on
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstn);

	AST_INTERNAL_FREE: assert property ((!mode_auto) [*2] |-> timing_state == TRS_FREE_RUN)
		else $error("state left free-run in internal mode");
	AST_CMD_ANSWER: assert property (cmd_valid |=> (cmd_accept ^ cmd_deny))
		else $error("command not answered exactly once");
	AST_FSEC_LOCK: assert property (cmd_valid && cmd_code == TRS_CMD_FORCE_SEC && lockout_on
		|=> cmd_deny)
		else $error("forced secondary accepted under lockout");
	AST_CLEAR_ALL: assert property (cmd_valid && cmd_code == TRS_CMD_CLEAR
		|=> cmd_accept && !lockout_on && !forced_on)
		else $error("clear did not clear commands");
	AST_OP_NORMAL: assert property (op_status == TRS_OP_NORMAL
		|-> pri_status != TRS_REF_UNAVAIL && sec_status != TRS_REF_UNAVAIL)
		else $error("normal operation status with a reference down");
	AST_SSM_UNAVAIL: assert property ((pri_status == TRS_REF_UNAVAIL) [*2] |-> pri_ssm == 4'h0)
		else $error("code shown for unavailable primary");
	AST_PRI_ACTIVE: assert property ((timing_state == TRS_NORMAL && !active_sec) [*2]
		|-> pri_status == TRS_REF_ACTIVE)
		else $error("primary locked but not reported active");
	AST_BOTH_DOWN: assert property ((pri_alarm && sec_alarm) [*3] |-> timing_state != TRS_NORMAL)
		else $error("normal state with both references failed");
	AST_LOCK_STAY: assert property (lockout_on && !active_sec && !cmd_valid |=> !active_sec)
		else $error("switch to secondary under lockout");
	AST_SINGLE_SEC: assert property ((src_sel == TRS_SRC_STM_SINGLE && mode_auto) [*3]
		|-> sec_status == TRS_REF_UNAVAIL)
		else $error("secondary used in single port setting");

	cover property (cmd_valid ##1 cmd_deny);
	cover property (timing_state == TRS_HOLDOVER);
	cover property (op_status == TRS_OP_RESTORE_WAIT);
endmodule : trs_timing_ref_sel_sva

bind trs_timing_ref_sel trs_timing_ref_sel_sva chk_u (.*);
`default_nettype wire

// [dv/trs_ref_partner.sv]
`default_nettype none
module trs_ref_partner (
	input  wire logic [7:0] md,
	output logic [3:0]      rclk
);
	timeunit 1ns;
	timeprecision 1fs;
	initial rclk = 4'h0;
	// Per reference: 0 stopped low, 1 nominal 2.048 MHz, 2 off-rate 2.5 MHz
	for (genvar i = 0; i < 4; i++) begin : g_ref
		always begin
			case (md[2*i +: 2])
				2'h1: begin
					#244.140625;
					rclk[i] = ~rclk[i];
				end
				2'h2: begin
					#200;
					rclk[i] = ~rclk[i];
				end
				default: begin
					#50;
					rclk[i] = 1'b0;
				end
			endcase
		end
	end
endmodule : trs_ref_partner
`default_nettype wire

// [dv/tb_trs_timing_ref_sel.sv]
`default_nettype none
module tb_trs_timing_ref_sel
	import trs_pkg::*;
;
	timeunit 1ns;
	timeprecision 1fs;
	logic clk_sys = 1'b0, rstn = 1'b0, mode_auto = 1'b0, e1_sync_variant = 1'b0;
	logic base_t1 = 1'b0, stm_single_unprot = 1'b0, revertive = 1'b0, ssm_enable = 1'b1;
	logic cmd_valid = 1'b0;
	trs_src_type src_sel = TRS_SRC_STM_PAIR;
	trs_cmd_type cmd_code = TRS_CMD_CLEAR;
	logic [1:0] e1_traffic = 2'h0, e1_sync_in = 2'h0, stm_los = 2'h0, stm_lof = 2'h0;
	logic [1:0] stm_msais = 2'h0, e1_los = 2'h0, stm_ref_clk, e1_ref_clk;
	logic [3:0] restore_delay_min = 4'h2, ssm_code_pri = TRS_SSM_PRC, ssm_code_sec = TRS_SSM_SEC;
	logic [7:0] md = 8'h00;
	trs_state_type timing_state;
	logic active_sec, pri_alarm, sec_alarm, cmd_accept, cmd_deny, lockout_on, forced_on;
	trs_ref_type pri_status, sec_status;
	logic [3:0] pri_ssm, sec_ssm;
	trs_op_type op_status;
	logic [31:0] freq_word;
	int fails = 0, n_tests = 0, n;

	// Gate of 625 cycles gives a nominal count of 64 edges
	trs_timing_ref_sel #(.GATE_CYCLES(625), .MINUTE_CYCLES(100)) dut_u (.*);
	trs_ref_partner ref_u (.md(md), .rclk({e1_ref_clk, stm_ref_clk}));

	always #25 clk_sys = ~clk_sys;

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fails++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	function automatic logic [31:0] pick(input int s);
		case (s)
			0: return 32'(timing_state);
			1: return 32'(active_sec);
			2: return 32'(pri_status);
			default: return 32'(op_status);
		endcase
	endfunction : pick

	task automatic waitc(input int s, input logic [31:0] v);
		n = 0;
		while (pick(s) !== v && n < 4000) begin
			@(posedge clk_sys);
			#1;
			n++;
		end
	endtask : waitc

	task automatic cmd(input trs_cmd_type c, input logic acc);
		@(posedge clk_sys);
		cmd_valid <= 1'b1;
		cmd_code <= c;
		@(posedge clk_sys);
		cmd_valid <= 1'b0;
		#1;
		chk(cmd_accept, acc);
		chk(cmd_deny, !acc);
	endtask : cmd

	// Primary defect k: 0 loss of signal, 1 loss of frame, 2 AIS, 3 do-not-use code
	task automatic pdef(input int k);
		@(posedge clk_sys);
		stm_los[0] <= (k == 0);
		stm_lof[0] <= (k == 1);
		stm_msais[0] <= (k == 2);
		ssm_code_pri <= (k == 3) ? TRS_SSM_DNU : TRS_SSM_PRC;
	endtask : pdef

	task automatic tally_and_finish();
		$display("checks=%0d mismatches=%0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : tally_and_finish

	initial begin
		#4ms;
		fails++;
		tally_and_finish();
	end

	initial begin
		repeat (4) @(posedge clk_sys);
		rstn <= 1'b1;
		mode_auto <= 1'b1;
		repeat (1500) @(posedge clk_sys);
		#1;
		chk(timing_state, TRS_FREE_RUN);
		mode_auto <= 1'b0;
		md <= 8'h05;
		repeat (1500) @(posedge clk_sys);
		#1;
		chk(timing_state, TRS_FREE_RUN);
		mode_auto <= 1'b1;
		waitc(0, TRS_NORMAL);
		chk(timing_state, TRS_NORMAL);
		waitc(3, TRS_OP_NORMAL);
		chk(op_status, TRS_OP_NORMAL);
		chk(active_sec, 1'b0);
		chk(sec_status, TRS_REF_STANDBY);
		chk(pri_ssm, TRS_SSM_PRC);
		chk(sec_ssm, TRS_SSM_SEC);
		ssm_enable <= 1'b0;
		repeat (3) @(posedge clk_sys);
		#1;
		chk(pri_ssm, 4'h0);
		ssm_enable <= 1'b1;
		for (int k = 0; k < 4; k++) begin
			pdef(k);
			waitc(1, 1);
			chk(active_sec, 1'b1);
			chk(pri_alarm, 1'b1);
			chk(pri_status, TRS_REF_UNAVAIL);
			pdef(9);
			waitc(2, TRS_REF_STANDBY);
			chk(active_sec, 1'b1);
			cmd(TRS_CMD_MAN_PRI, 1'b1);
			repeat (2) @(posedge clk_sys);
			#1;
			chk(active_sec, 1'b0);
		end
		revertive <= 1'b1;
		pdef(0);
		waitc(1, 1);
		pdef(9);
		waitc(3, TRS_OP_RESTORE_WAIT);
		chk(op_status, TRS_OP_RESTORE_WAIT);
		waitc(1, 0);
		chk(32'(n >= 196 && n <= 204), 32'h1);
		revertive <= 1'b0;
		cmd(TRS_CMD_LOCKOUT, 1'b1);
		chk(lockout_on, 1'b1);
		cmd(TRS_CMD_FORCE_SEC, 1'b0);
		pdef(0);
		waitc(0, TRS_HOLDOVER);
		chk(timing_state, TRS_HOLDOVER);
		chk(active_sec, 1'b0);
		waitc(3, TRS_OP_UNAVAIL_REF);
		chk(op_status, TRS_OP_UNAVAIL_REF);
		cmd(TRS_CMD_CLEAR, 1'b1);
		waitc(1, 1);
		chk(timing_state, TRS_NORMAL);
		cmd(TRS_CMD_FORCE_PRI, 1'b1);
		chk(forced_on, 1'b1);
		waitc(0, TRS_HOLDOVER);
		chk(timing_state, TRS_HOLDOVER);
		cmd(TRS_CMD_MAN_SEC, 1'b0);
		cmd(TRS_CMD_CLEAR, 1'b1);
		waitc(0, TRS_NORMAL);
		chk(timing_state, TRS_NORMAL);
		md <= 8'h09;
		waitc(0, TRS_HOLDOVER);
		chk(timing_state, TRS_HOLDOVER);
		chk(sec_alarm, 1'b1);
		repeat (1300) @(posedge clk_sys);
		#1;
		chk(freq_word, 32'h40);
		md <= 8'h05;
		pdef(9);
		waitc(0, TRS_NORMAL);
		chk(timing_state, TRS_NORMAL);
		mode_auto <= 1'b0;
		src_sel <= TRS_SRC_STM_SINGLE;
		repeat (3) @(posedge clk_sys);
		mode_auto <= 1'b1;
		waitc(0, TRS_NORMAL);
		pdef(0);
		waitc(0, TRS_HOLDOVER);
		chk(timing_state, TRS_HOLDOVER);
		mode_auto <= 1'b0;
		src_sel <= TRS_SRC_E1_PAIR;
		e1_sync_variant <= 1'b1;
		e1_sync_in <= 2'h3;
		md <= 8'h55;
		pdef(9);
		repeat (3) @(posedge clk_sys);
		mode_auto <= 1'b1;
		waitc(0, TRS_NORMAL);
		chk(timing_state, TRS_NORMAL);
		e1_los[0] <= 1'b1;
		waitc(1, 1);
		chk(active_sec, 1'b1);
		tally_and_finish();
	end
endmodule : tb_trs_timing_ref_sel
`default_nettype wire
